// ### tct_regs.svh
// Purpose: register offsets, field positions and reset values of the timer
// Assumes: byte address = channel * 0x20 + word * 2, global word at 0x60
// Notes: word indices below are bus_addr_i[4:1]
`ifndef TCT_REGS_SVH
`define TCT_REGS_SVH

// word index inside a channel block (channel = bus_addr_i[6:5])
`define TCT_W_CTRL 4'h0
`define TCT_W_IO 4'h1
`define TCT_W_IRQ 4'h2
`define TCT_W_CNT 4'h3
`define TCT_W_GRA 4'h4
`define TCT_W_GRB 4'h5
`define TCT_W_GRC 4'h6
`define TCT_W_GRD 4'h7
`define TCT_CH_GLOBAL 2'h3
`define TCT_W_GLB 4'h0

// reset values
`define TCT_START_RST 8'h00
`define TCT_SYNC_RST 8'h00
`define TCT_CTRL_RST 8'h00
`define TCT_MODE_RST 3'h0
`define TCT_IEN_RST 5'h00
`define TCT_IO_RST 4'h0
`define TCT_CNT_RST 16'h0000
`define TCT_GR_RST 16'hffff
`define TCT_STAT_FIXED 8'hc0
`define TCT_IMPL_MASK 8'h07

// control register fields
`define TCT_PSC_MSB 2
`define TCT_PSC_LSB 0
`define TCT_CKEG_MSB 4
`define TCT_CKEG_LSB 3
`define TCT_CCLR_MSB 7
`define TCT_CCLR_LSB 5
`define TCT_CASCADE 3'h7
`define TCT_CKEG_RISE 2'h0
`define TCT_CKEG_FALL 2'h1

// mode, pin control, status fields
`define TCT_MD_PWM 0
`define TCT_MD_BFA 1
`define TCT_IO_INIT 2
`define TCT_IO_CAP 3
`define TCT_OVF_BIT 4

`endif

// ### tct_pkg.sv
// Purpose: shared types of the three channel timer
// Assumes: nothing
// Notes: encodings of clear source, compare action and capture edge
package tct_pkg;
   typedef enum logic [2:0] {
      TCT_CLR_NONE = 3'h0,
      TCT_CLR_A = 3'h1,
      TCT_CLR_B = 3'h2,
      TCT_CLR_SYNC = 3'h3,
      TCT_CLR_C = 3'h5,
      TCT_CLR_D = 3'h6
   } tct_clr_e;
   typedef enum logic [1:0] {
      TCT_ACT_KEEP = 2'h0,
      TCT_ACT_LOW = 2'h1,
      TCT_ACT_HIGH = 2'h2,
      TCT_ACT_TOGGLE = 2'h3
   } tct_act_e;
   typedef enum logic [1:0] {
      TCT_EDGE_NONE = 2'h0,
      TCT_EDGE_RISE = 2'h1,
      TCT_EDGE_FALL = 2'h2,
      TCT_EDGE_BOTH = 2'h3
   } tct_edge_e;
endpackage

// ### tct_pin_unit.sv
// Purpose: one capture/compare pin: input edge detect and output level
// Assumes: pin_i is asynchronous to ref_clk_i
// Notes: level holds whenever no initial load or compare event arrives
`timescale 1ns/100ps
`include "tct_regs.svh"
module tct_pin_unit (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // pin side
   input wire logic pin_i,
   input wire logic [1:0] cap_edge_i,
   // output control
   input wire logic init_load_i,
   input wire logic init_lvl_i,
   input wire logic cm_i,
   input wire logic [1:0] act_i,
   // results
   output logic edge_o,
   output logic level_o
);
   logic s1;
   logic s2;
   logic s3;
   wire rise = s2 & ~s3;
   wire fall = ~s2 & s3;

   always_comb begin
      case (tct_pkg::tct_edge_e'(cap_edge_i))
         tct_pkg::TCT_EDGE_RISE: edge_o = rise;
         tct_pkg::TCT_EDGE_FALL: edge_o = fall;
         tct_pkg::TCT_EDGE_BOTH: edge_o = rise | fall;
         default: edge_o = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         level_o <= 1'b0;
      end else if (init_load_i) begin
         level_o <= init_lvl_i; // RULE4 RULE17
      end else if (cm_i) begin
         case (tct_pkg::tct_act_e'(act_i))
            tct_pkg::TCT_ACT_LOW: level_o <= 1'b0; // RULE17 RULE18
            tct_pkg::TCT_ACT_HIGH: level_o <= 1'b1; // RULE17 RULE18
            tct_pkg::TCT_ACT_TOGGLE: level_o <= ~level_o; // RULE17
            default: level_o <= level_o;
         endcase
      end
   end
endmodule // tct_pin_unit

// ### tct_timer_core.sv
// Purpose: three channel 16-bit up-counting timer with capture/compare pins
// Assumes: ref_clk_i 100 MHz, srst_i synchronous active high
// Notes: slots 0-3 are channel 0 A-D, 4-5 channel 1 A-B, 6-7 channel 2 A-B
//
// Behaviour
// (RULE1) each counter counts only while its run bit is 1; bit n runs channel n
// (RULE2) start register 8 bits, resets to zero, upper five bits read zero
// (RULE3) stopping a channel freezes the counter and keeps the pin level
// (RULE4) pin control write while stopped drives the new initial level at once
// (RULE5) sync register 8 bits, reset zero, bits 2..0 flag sync channels
// (RULE6) counter write on a sync channel loads every sync channel together
// (RULE7) a sync channel clear also clears sync channels choosing sync clear
// (RULE8) software sets at least two sync bits and programs clear sources
// (RULE9) counters and general registers take only full 16-bit accesses
// (RULE10) eight-bit registers accept byte accesses on either lane or both
// (RULE11) up counting: free, periodic, event; general regs compare or capture
// (RULE12) prescaler select picks counter clock, edge select picks active edge
// (RULE13) reset leaves free-running; ffff wrap sets overflow, counting goes on
// (RULE14) overflow flag with overflow enable raises the channel interrupt
// (RULE15) periodic mode: match on clear register sets flag and clears counter
// (RULE16) compare or capture flag with its enable raises the interrupt
// (RULE17) compare match drives low, high or toggle; initial level before
// (RULE18) a fixed level already on the pin leaves it unchanged
// (RULE19) selected capture edge copies the counter into the general register
// (RULE20) channels 0 and 1 may capture on the other channel's clock or match
// (RULE21) buffered compare loads from buffer; buffered capture pushes old value
// (RULE22) channels 1 and 2 cascade to 32 bits; pwm duty 0 to 100 percent
// (RULE23) cascade: channel 1 upper half counts channel 2 overflows, select 111
// (RULE24) only channel 0 buffers: third buffers first, fourth buffers second
// (RULE25) match is seen on a counting cycle where counter equals register
`timescale 1ns/100ps
`include "tct_regs.svh"
module tct_timer_core (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // register port, 16-bit data with byte lanes
   input wire logic [6:0] bus_addr_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [1:0] bus_be_i,
   input wire logic [15:0] bus_wdata_i,
   output logic [15:0] bus_rdata_o,
   // external count clocks and capture/compare pins
   input wire logic [3:0] ext_clk_i,
   input wire logic [7:0] cc_pin_i,
   output logic [7:0] cc_pin_o,
   output logic [7:0] cc_pin_oe_o,
   // interrupt requests, one per channel
   output logic [2:0] irq_o
);
   logic [7:0] start;
   logic [7:0] sync;
   logic [2:0][7:0] ctrl;
   logic [2:0][2:0] mode;
   logic [2:0][4:0] ien;
   logic [2:0] ovf;
   logic [7:0] flag;
   logic [7:0][3:0] io;
   logic [2:0][15:0] cnt;
   logic [7:0][15:0] gr;
   logic [5:0] pre;
   logic [3:0] ext_s1;
   logic [3:0] ext_s2;
   logic [3:0] ext_s3;
   logic [2:0] tick;
   logic [2:0] own_clr;
   logic [2:0] clr;
   logic [2:0] ovf_ev;
   logic [2:0] cnt_ld;
   logic [7:0] match;
   logic [7:0] cap;
   logic [7:0] pin_edge;
   logic [2:0][15:0] rdw;
   logic [15:0] next_rdata;

   // register port decode
   wire [1:0] a_ch = bus_addr_i[6:5];
   wire [3:0] a_w = bus_addr_i[4:1];
   wire wr_hi = bus_wr_i & bus_be_i[1];
   wire wr_lo = bus_wr_i & bus_be_i[0];
   wire wr16 = wr_hi & wr_lo;
   wire glb = (a_ch == `TCT_CH_GLOBAL) && (a_w == `TCT_W_GLB);
   wire cnt_wr = wr16 && (a_w == `TCT_W_CNT) && (a_ch != `TCT_CH_GLOBAL);
   wire [3:0] sync4 = {1'b0, sync[2:0]};
   wire [2:0] run = start[2:0];
   wire [7:0] ev = match | cap;

   // free prescaler and external clock synchronisers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pre <= 6'h00;
         ext_s1 <= 4'h0;
         ext_s2 <= 4'h0;
         ext_s3 <= 4'h0;
      end else begin
         pre <= pre + 6'h01;
         ext_s1 <= ext_clk_i;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   // start and sync registers, upper five bits held at zero
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         start <= `TCT_START_RST; // RULE2
         sync <= `TCT_SYNC_RST; // RULE5
      end else begin
         if (glb && wr_hi) begin
            start <= bus_wdata_i[15:8] & `TCT_IMPL_MASK; // RULE2 RULE10
         end
         if (glb && wr_lo) begin
            sync <= bus_wdata_i[7:0] & `TCT_IMPL_MASK; // RULE5 RULE10
         end
      end
   end

   genvar c;
   generate
      for (c = 0; c < 3; c = c + 1) begin : g_ch
         localparam int B = (c == 0) ? 0 : 2 * c + 2;
         wire sel = (a_ch == 2'(c));
         wire [2:0] psc = ctrl[c][`TCT_PSC_MSB:`TCT_PSC_LSB];
         wire [1:0] ckeg = ctrl[c][`TCT_CKEG_MSB:`TCT_CKEG_LSB];
         wire e2 = ext_s2[psc[1:0]];
         wire e3 = ext_s3[psc[1:0]];
         wire stat_wr = sel && (a_w == `TCT_W_IRQ) && wr_lo;
         wire [3:0] fl = (c == 0) ? flag[3:0] :
                         {2'b00, flag[B + 1], flag[B]};
         wire [7:0] st = `TCT_STAT_FIXED | {3'h0, ovf[c], fl};
         wire [15:0] rd_io = (c == 0) ? {io[1], io[0], io[3], io[2]} :
                             {io[B + 1], io[B], 8'h00};
         wire others = |(own_clr & sync[2:0] & ~(3'(1) << c));
         logic ext_ev;
         logic src;
         logic oc;
         logic [15:0] r;

         always_comb begin
            if (ckeg == `TCT_CKEG_RISE) begin
               ext_ev = e2 & ~e3;
            end else if (ckeg == `TCT_CKEG_FALL) begin
               ext_ev = ~e2 & e3;
            end else begin
               ext_ev = e2 ^ e3;
            end
         end

         always_comb begin
            case (psc)
               3'h0: src = 1'b1;
               3'h1: src = &pre[1:0];
               3'h2: src = &pre[3:0];
               3'h3: src = &pre;
               default: begin
                  if (c == 1 && psc == `TCT_CASCADE) begin
                     src = ovf_ev[2]; // RULE22 RULE23
                  end else begin
                     src = ext_ev; // RULE11 RULE12
                  end
               end
            endcase
         end

         assign tick[c] = run[c] & src; // RULE1 RULE3 RULE12

         always_comb begin
            case (tct_pkg::tct_clr_e'(ctrl[c][`TCT_CCLR_MSB:`TCT_CCLR_LSB]))
               tct_pkg::TCT_CLR_A: oc = ev[B]; // RULE15
               tct_pkg::TCT_CLR_B: oc = ev[B + 1]; // RULE15
               tct_pkg::TCT_CLR_C: oc = (c == 0) & ev[2];
               tct_pkg::TCT_CLR_D: oc = (c == 0) & ev[3];
               default: oc = 1'b0;
            endcase
         end

         assign own_clr[c] = oc;
         // RULE7 RULE8
         assign clr[c] = oc | (sync[c] & others &
            (ctrl[c][`TCT_CCLR_MSB:`TCT_CCLR_LSB] == tct_pkg::TCT_CLR_SYNC));
         // RULE6 RULE9
         assign cnt_ld[c] = cnt_wr & (sel | (sync[c] & sync4[a_ch]));
         assign ovf_ev[c] = tick[c] & (&cnt[c]) & ~cnt_ld[c]; // RULE13

         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               cnt[c] <= `TCT_CNT_RST;
            end else if (cnt_ld[c]) begin
               cnt[c] <= bus_wdata_i; // RULE6
            end else if (clr[c]) begin
               cnt[c] <= `TCT_CNT_RST; // RULE7 RULE15
            end else if (tick[c]) begin
               cnt[c] <= cnt[c] + 16'h0001; // RULE11 RULE13
            end
         end

         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               ctrl[c] <= `TCT_CTRL_RST; // RULE13
               mode[c] <= `TCT_MODE_RST;
               ien[c] <= `TCT_IEN_RST;
               ovf[c] <= 1'b0;
            end else begin
               if (sel && a_w == `TCT_W_CTRL && wr_hi) begin
                  ctrl[c] <= bus_wdata_i[15:8]; // RULE10
               end
               if (sel && a_w == `TCT_W_CTRL && wr_lo) begin
                  mode[c] <= bus_wdata_i[2:0]; // RULE10
               end
               if (sel && a_w == `TCT_W_IRQ && wr_hi) begin
                  ien[c] <= bus_wdata_i[12:8];
               end
               // set wins over a clearing zero write
               ovf[c] <= ovf_ev[c] | (ovf[c] &
                  ~(stat_wr & ~bus_wdata_i[`TCT_OVF_BIT])); // RULE13
            end
         end

         assign irq_o[c] = |({ovf[c], fl} & ien[c]); // RULE14 RULE16

         always_comb begin
            case (a_w)
               `TCT_W_CTRL: r = {ctrl[c], 5'h00, mode[c]};
               `TCT_W_IO: r = rd_io;
               `TCT_W_IRQ: r = {3'h0, ien[c], st};
               `TCT_W_CNT: r = cnt[c];
               `TCT_W_GRA: r = gr[B];
               `TCT_W_GRB: r = gr[B + 1];
               `TCT_W_GRC: r = (c == 0) ? gr[2] : 16'h0000;
               `TCT_W_GRD: r = (c == 0) ? gr[3] : 16'h0000;
               default: r = 16'h0000;
            endcase
         end

         assign rdw[c] = r;
      end
   endgenerate

   genvar s;
   generate
      for (s = 0; s < 8; s = s + 1) begin : g_slot
         localparam int C = (s < 4) ? 0 : (s < 6) ? 1 : 2;
         localparam int R = (s < 4) ? s : (s - 4) % 2;
         localparam int L = (R < 2) ? 8 + 4 * R : 4 * (R - 2);
         localparam bit LEAD = (R % 2 == 0);
         localparam int PP = LEAD ? s + 1 : s - 1;
         localparam int PB = (s < 2) ? s + 2 : s;
         localparam int PS = (s == 2 || s == 3) ? s - 2 : s;
         localparam int MB = (s < 2) ? s + 1 : (s < 4) ? s - 1 : 1;
         localparam bit ALT_OK = (s == 0 || s == 1 || s == 4 || s == 5);
         localparam int OC = (C == 0) ? 1 : 0;
         localparam int OS = (C == 0) ? 4 : 0;
         wire cmp = ~io[s][`TCT_IO_CAP];
         wire pwm = mode[C][`TCT_MD_PWM];
         wire bmode = (s < 4) && mode[0][MB];
         wire io_wr = (a_ch == 2'(C)) && (a_w == `TCT_W_IO) &&
                      ((R < 2) ? wr_hi : wr_lo);
         wire gr_wr = wr16 && (a_ch == 2'(C)) &&
                      (a_w == `TCT_W_GRA + 4'(R));
         wire st_clr = (a_ch == 2'(C)) && (a_w == `TCT_W_IRQ) && wr_lo &&
                       !bus_wdata_i[R];
         wire alt = ALT_OK && io[s][`TCT_IO_INIT];
         wire alt_ev = io[s][0] ? tick[OC] : match[OS];
         wire pcm;
         wire [1:0] pact;

         // RULE11 RULE25
         assign match[s] = tick[C] & cmp & (cnt[C] == gr[s]);
         // RULE19 RULE20
         assign cap[s] = ~cmp & (alt ? alt_ev : pin_edge[s]);

         // pwm pairs drive the lead pin; equal pair values never toggle
         assign pcm = LEAD ? (pwm ? (match[s] | match[PP]) &
                       (gr[s] != gr[PP]) : match[s]) :
                      (~pwm & match[s]); // RULE22
         assign pact = (LEAD && pwm && match[PP]) ? io[PP][1:0] :
                       io[s][1:0];
         assign cc_pin_oe_o[s] = cmp & ~(pwm & ~LEAD);

         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               io[s] <= `TCT_IO_RST;
               flag[s] <= 1'b0;
            end else begin
               if (io_wr) begin
                  io[s] <= bus_wdata_i[L +: 4]; // RULE10
               end
               // set wins over a clearing zero write
               flag[s] <= ev[s] | (flag[s] & ~st_clr); // RULE15 RULE16
            end
         end

         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               gr[s] <= `TCT_GR_RST;
            end else if (gr_wr) begin
               gr[s] <= bus_wdata_i; // RULE9
            end else if (cap[s]) begin
               gr[s] <= cnt[C]; // RULE19 RULE21
            end else if (s < 2 && bmode && match[s]) begin
               gr[s] <= gr[PB]; // RULE21 RULE24
            end else if (s >= 2 && s < 4 && bmode && cap[PS]) begin
               gr[s] <= gr[PS]; // RULE21 RULE24
            end
         end

         tct_pin_unit u_pin (
            .ref_clk_i(ref_clk_i),
            .srst_i(srst_i),
            .pin_i(cc_pin_i[s]),
            .cap_edge_i(io[s][1:0]),
            .init_load_i(io_wr & ~run[C]), // RULE4
            .init_lvl_i(bus_wdata_i[L + `TCT_IO_INIT]),
            .cm_i(pcm), // RULE3 RULE17 RULE18
            .act_i(pact),
            .edge_o(pin_edge[s]),
            .level_o(cc_pin_o[s])
         );
      end
   endgenerate

   // read data registered one cycle after the strobe
   always_comb begin
      case (a_ch)
         2'h0: next_rdata = rdw[0];
         2'h1: next_rdata = rdw[1];
         2'h2: next_rdata = rdw[2];
         default: next_rdata = glb ? {start, sync} : 16'h0000; // RULE2 RULE5
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         bus_rdata_o <= 16'h0000;
      end else if (bus_rd_i) begin
         bus_rdata_o <= next_rdata;
      end
   end
endmodule // tct_timer_core

// ### tct_pin_model.sv
// Purpose: far side of the capture/compare pins and count clocks
// Assumes: bench changes drv_lvl_i just after a falling clock edge
// Notes: a pin the core drives reads back the core's own level
`timescale 1ns/100ps
module tct_pin_model (
   // core side
   input wire logic [7:0] pin_o_i,
   input wire logic [7:0] pin_oe_i,
   // stimulus
   input wire logic [7:0] drv_lvl_i,
   input wire logic [3:0] ext_lvl_i,
   // to the core
   output logic [7:0] pin_i_o,
   output logic [3:0] ext_clk_o
);
   // wire level resolved from both drivers
   assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_lvl_i);
   // count clocks come straight from the bench, idle low
   assign ext_clk_o = ext_lvl_i;
endmodule // tct_pin_model

// ### tct_timer_core_sva.sv
// Purpose: port level checks of the timer core
// Assumes: bound into tct_timer_core
// Notes: run0 mirrors the channel 0 start bit written over the bus
`timescale 1ns/100ps
module tct_timer_core_sva (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // register port
   input wire logic [6:0] bus_addr_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [1:0] bus_be_i,
   input wire logic [15:0] bus_wdata_i,
   input wire logic [15:0] bus_rdata_o,
   // pins and interrupts
   input wire logic [7:0] cc_pin_o,
   input wire logic [7:0] cc_pin_oe_o,
   input wire logic [2:0] irq_o
);
   logic run0;
   wire glb_rd = bus_rd_i && bus_addr_i == 7'h60;
   wire st_rd = bus_rd_i && bus_addr_i[6:5] != 2'h3 && bus_addr_i[4:1] == 4'h2;
   wire hole_rd = bus_rd_i && bus_addr_i[4];
   wire run_wr = bus_wr_i && bus_addr_i == 7'h60 && bus_be_i[1];
   always_ff @(posedge ref_clk_i) begin
      if (srst_i)
         run0 <= 1'b0;
      else if (run_wr)
         run0 <= bus_wdata_i[8];
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   a_start_upper_zero: assert property (
      glb_rd |=> bus_rdata_o[15:11] == 5'h00)
      else $error("start high bits set");
   a_sync_upper_zero: assert property (
      glb_rd |=> bus_rdata_o[7:3] == 5'h00) else $error("sync high bits set");
   a_status_fixed_bits: assert property (
      st_rd |=> bus_rdata_o[7:5] == 3'h6)
      else $error("status fixed bits wrong");
   a_hole_reads_zero: assert property (
      hole_rd |=> bus_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (
      !bus_rd_i |=> $stable(bus_rdata_o)) else $error("read data moved");
   a_reset_pins_init: assert property (
      $fell(srst_i) |-> cc_pin_oe_o == 8'hff && cc_pin_o == 8'h00)
      else $error("pins not initial after reset");
   a_reset_irq_low: assert property (
      $fell(srst_i) |-> irq_o == 3'h0) else $error("interrupt after reset");
   a_stop_pins_hold: assert property (
      !run0 && !$past(srst_i) && !$past(bus_wr_i) && !$past(bus_wr_i, 2)
      && !$past(bus_wr_i, 3) |-> $stable(cc_pin_o[3:0]))
      else $error("stopped channel pin moved");
endmodule // tct_timer_core_sva

bind tct_timer_core tct_timer_core_sva u_sva (
   .ref_clk_i(ref_clk_i),
   .srst_i(srst_i),
   .bus_addr_i(bus_addr_i),
   .bus_wr_i(bus_wr_i),
   .bus_rd_i(bus_rd_i),
   .bus_be_i(bus_be_i),
   .bus_wdata_i(bus_wdata_i),
   .bus_rdata_o(bus_rdata_o),
   .cc_pin_o(cc_pin_o),
   .cc_pin_oe_o(cc_pin_oe_o),
   .irq_o(irq_o)
);

// ### tct_timer_core_tb.sv
// Purpose: self-checking bench of the three channel timer core
// Assumes: inputs change on the falling clock edge
// Notes: reset checks first, then table rows, then hand-written cases
`timescale 1ns/100ps
module tct_timer_core_tb;
   typedef struct packed {
      logic [6:0] a;
      logic [1:0] be;
      logic [15:0] d;
      logic [15:0] e;
   } tct_row_s;
   localparam tct_row_s ROWS [0:7] = '{
      '{7'h06, 2'b01, 16'h1234, 16'h0000},
      '{7'h06, 2'b11, 16'h1234, 16'h1234},
      '{7'h08, 2'b10, 16'h0000, 16'hffff},
      '{7'h00, 2'b10, 16'h5a33, 16'h5a00},
      '{7'h00, 2'b01, 16'hff07, 16'h5a07},
      '{7'h00, 2'b11, 16'h0000, 16'h0000},
      '{7'h10, 2'b11, 16'hbeef, 16'h0000},
      '{7'h60, 2'b11, 16'hf8f8, 16'h0000}};
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [6:0] bus_addr_i = 7'h00;
   logic bus_wr_i = 1'b0;
   logic bus_rd_i = 1'b0;
   logic [1:0] bus_be_i = 2'b00;
   logic [15:0] bus_wdata_i = 16'h0000;
   logic [15:0] bus_rdata_o;
   logic [3:0] ext_clk_i;
   logic [7:0] cc_pin_i, cc_pin_o, cc_pin_oe_o;
   logic [7:0] drv_lvl = 8'h00;
   logic [3:0] ext_lvl = 4'h0;
   logic [2:0] irq_o;
   int miscompares = 0;
   int checks = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   tct_timer_core dut (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .bus_addr_i(bus_addr_i),
      .bus_wr_i(bus_wr_i),
      .bus_rd_i(bus_rd_i),
      .bus_be_i(bus_be_i),
      .bus_wdata_i(bus_wdata_i),
      .bus_rdata_o(bus_rdata_o),
      .ext_clk_i(ext_clk_i),
      .cc_pin_i(cc_pin_i),
      .cc_pin_o(cc_pin_o),
      .cc_pin_oe_o(cc_pin_oe_o),
      .irq_o(irq_o)
   );
   tct_pin_model u_pins (
      .pin_o_i(cc_pin_o),
      .pin_oe_i(cc_pin_oe_o),
      .drv_lvl_i(drv_lvl),
      .ext_lvl_i(ext_lvl),
      .pin_i_o(cc_pin_i),
      .ext_clk_o(ext_clk_i)
   );
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [1:0] be,
                     input logic [15:0] d);
      @(negedge ref_clk_i);
      bus_addr_i = a;
      bus_be_i = be;
      bus_wdata_i = d;
      bus_wr_i = 1'b1;
      @(negedge ref_clk_i);
      bus_wr_i = 1'b0;
   endtask
   task automatic rdc(input logic [6:0] a, input logic [15:0] e);
      @(negedge ref_clk_i);
      bus_addr_i = a;
      bus_rd_i = 1'b1;
      @(negedge ref_clk_i);
      bus_rd_i = 1'b0;
      check(bus_rdata_o, e);
   endtask
   task automatic wait_irq(input int b);
      int n;
      n = 0;
      while (irq_o[b] !== 1'b1 && n < 400) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (n == 400) begin
         miscompares++;
         $display("MISMATCH at %0t: interrupt never came", $time);
         wrap_up();
      end
   endtask
   // run the channels in go for 21 clock ticks, then stop them
   task automatic spin(input logic [15:0] go);
      wr(7'h60, 2'b10, go);
      repeat (19) @(negedge ref_clk_i);
      wr(7'h60, 2'b10, 16'h0000);
   endtask
   // run channel 0 to one compare match of register A, then stop it
   task automatic cm(input logic [15:0] io, input logic e);
      wr(7'h02, 2'b10, io);
      repeat (2) @(negedge ref_clk_i);
      check({15'h0, cc_pin_o[0]}, 16'h0001);
      wr(7'h06, 2'b11, 16'h0000);
      wr(7'h60, 2'b10, 16'h0100);
      wait_irq(0);
      wr(7'h60, 2'b10, 16'h0000);
      repeat (5) @(negedge ref_clk_i);
      check({15'h0, cc_pin_o[0]}, {15'h0, e});
      rdc(7'h04, 16'h01c1);
      wr(7'h04, 2'b01, 16'h0000);
      check({13'h0, irq_o}, 16'h0000);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      srst_i = 1'b0;
      check({8'h0, cc_pin_oe_o}, 16'h00ff);
      check({8'h0, cc_pin_o}, 16'h0000);
      rdc(7'h60, 16'h0000);
      rdc(7'h04, 16'h00c0);
      rdc(7'h08, 16'hffff);
      rdc(7'h06, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         wr(ROWS[i].a, ROWS[i].be, ROWS[i].d);
         rdc(ROWS[i].a, ROWS[i].e);
      end
      $display("test table done");
      wr(7'h60, 2'b01, 16'h0003);
      wr(7'h06, 2'b11, 16'h4321);
      rdc(7'h26, 16'h4321);
      rdc(7'h46, 16'h0000);
      wr(7'h60, 2'b01, 16'h0000);
      $display("test sync preset done");
      wr(7'h06, 2'b11, 16'h0000);
      spin(16'h0100);
      rdc(7'h06, 16'h0015);
      rdc(7'h26, 16'h4321);
      $display("test run stop done");
      wr(7'h08, 2'b11, 16'h0004);
      wr(7'h00, 2'b10, 16'h2000);
      wr(7'h04, 2'b10, 16'h0100);
      cm(16'h0700, 1'b0);
      cm(16'h0600, 1'b1);
      $display("test compare done");
      wr(7'h22, 2'b10, 16'h0900);
      check({15'h0, cc_pin_oe_o[4]}, 16'h0000);
      @(negedge ref_clk_i);
      drv_lvl = 8'h10;
      repeat (6) @(negedge ref_clk_i);
      rdc(7'h28, 16'h4321);
      $display("test capture done");
      wr(7'h20, 2'b10, 16'h0700);
      wr(7'h46, 2'b11, 16'hfffe);
      wr(7'h44, 2'b10, 16'h1000);
      wr(7'h60, 2'b10, 16'h0600);
      wait_irq(2);
      wr(7'h60, 2'b10, 16'h0000);
      rdc(7'h44, 16'h10d3);
      rdc(7'h26, 16'h4322);
      $display("test overflow cascade done");
      wr(7'h20, 2'b10, 16'h6000);
      wr(7'h60, 2'b01, 16'h0003);
      wr(7'h06, 2'b11, 16'h0000);
      spin(16'h0300);
      rdc(7'h06, 16'h0001);
      rdc(7'h26, 16'h0001);
      wr(7'h60, 2'b01, 16'h0000);
      $display("test sync clear done");
      wr(7'h0c, 2'b11, 16'h0006);
      wr(7'h00, 2'b01, 16'h0003);
      check({14'h0, cc_pin_oe_o[1:0]}, 16'h0001);
      wr(7'h06, 2'b11, 16'h0000);
      spin(16'h0100);
      rdc(7'h08, 16'h0006);
      rdc(7'h06, 16'h0002);
      $display("test buffer pwm done");
      wr(7'h40, 2'b10, 16'h0c00);
      wr(7'h46, 2'b11, 16'h0000);
      wr(7'h60, 2'b10, 16'h0400);
      repeat (5) begin
         repeat (4) @(negedge ref_clk_i);
         ext_lvl[0] = ~ext_lvl[0];
      end
      repeat (4) @(negedge ref_clk_i);
      wr(7'h60, 2'b10, 16'h0000);
      rdc(7'h46, 16'h0002);
      $display("test external clock done");
      wrap_up();
   end
endmodule // tct_timer_core_tb
